// File: srfl_pkg.sv
// package of constants and carrier types for the s-record flash loader
package srfl_pkg;
    localparam int SRFL_CLK_HZ = 100000000;
    localparam int SRFL_ACK_TMO_MS = 100;
    localparam int SRFL_BOOT_WAIT_S = 5;
    localparam int SRFL_BOOT_WAIT_CYC = SRFL_CLK_HZ * SRFL_BOOT_WAIT_S;
    localparam int SRFL_VIRT_CLK_HZ = 9600;
    localparam int SRFL_VIRT_FRAME_CLKS = 192;
    localparam int SRFL_VIRT_CHAR_PER_S = 3000;
    localparam int SRFL_VIRT_CHAR_CYC = SRFL_CLK_HZ / SRFL_VIRT_CHAR_PER_S;
    localparam int SRFL_FIFO_W = 8;
    localparam int SRFL_FIFO_D = 32;
    localparam int SRFL_CNT_W = 16;
    localparam logic [7:0] SRFL_ESC = 8'h1b;
    localparam logic [7:0] SRFL_CR = 8'h0d;
    localparam logic [7:0] SRFL_LF = 8'h0a;
    localparam logic [7:0] SRFL_CH_S = 8'h53;
    localparam logic [7:0] SRFL_CH_8 = 8'h38;
    localparam logic [1:0] SRFL_PORT_PRI = 2'h0;
    localparam logic [1:0] SRFL_PORT_SEC = 2'h1;
    localparam logic [1:0] SRFL_PORT_VIRT = 2'h2;

    // message selectors
    typedef enum logic [2:0] {
        SRFL_MSG_NONE,
        SRFL_MSG_ERASING,
        SRFL_MSG_READY,
        SRFL_MSG_ACK,
        SRFL_MSG_COUNT,
        SRFL_MSG_DONE,
        SRFL_MSG_ERROR,
        SRFL_MSG_BANNER
    } srfl_msg_t;

    typedef struct packed {
        logic [7:0] data;
        logic [1:0] port;
    } srfl_char_t;

    typedef struct packed {
        logic start;
        logic ack_mode;
        logic boot;
        logic [1:0] port;
    } srfl_cmd_t;
endpackage

// File: srfl_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
`default_nettype none
module srfl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic wr, rd;

    assign in_ready = (cnt != (AW+1)'(DEPTH));
    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];
    assign wr = in_valid && in_ready;
    assign rd = out_valid && out_ready;

    always_comb
    begin
        next_wp = wr ? wp + 1'b1 : wp;
        next_rp = rd ? rp + 1'b1 : rp;
        next_cnt = cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end
        else
        begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (wr)
            mem[wp] <= in_data;
    end
endmodule
`default_nettype wire

// File: srfl_loader.sv
// s-record flash loader command interpreter
// How it works
// - ack program command erases flash, prints erasing, then ready when done
// - each good record is programmed then acknowledged, first one as 0000
// - acknowledgement carries four hex digit count, plus one per record
// - after final acknowledgement done is printed; s8 ends the file
// - no record retransmission; recovery only by abort and restart
// - echo and prompt suppressed on the active port while programming
// - ack mode accepted on both serial ports and the virtual port
// - reset command reboots; host waits 5 s before testing
// - banner never printed on the virtual port
// - virtual port paces characters at 3000 per second
// - boot loader talks only on the primary serial port
// - esc at boot message enters boot loader with single line banner
// - boot program command enables handshake, erases, prints ready
// - plain mode reports record count and prints done when error free
// - a record error while receiving or programming aborts the run and prints an error message
// - configuration block erased only when its size changed
`timescale 1ns/1ps
`default_nettype none
module srfl_loader
    import srfl_pkg::*;
#(
    parameter int BOOT_WAIT_CYC = srfl_pkg::SRFL_BOOT_WAIT_CYC
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire srfl_pkg::srfl_cmd_t CMD,
    input wire logic CMD_VALID,
    input wire logic RESET_CMD,
    input wire logic BOOT_ESC,
    input wire logic RX_VALID,
    output logic RX_READY,
    input wire srfl_pkg::srfl_char_t RX_CHAR,
    input wire logic REC_ERROR,
    input wire logic CFG_SIZE_DIFF,
    output logic ERASE_REQ,
    output logic CFG_ERASE_REQ,
    input wire logic ERASE_DONE,
    output logic PROG_REQ,
    input wire logic PROG_DONE,
    output logic HW_HANDSHAKE,
    output logic ECHO_ENABLE,
    output logic PROMPT_ENABLE,
    output logic [1:0] ACTIVE_PORT,
    output srfl_pkg::srfl_msg_t MSG,
    output logic [1:0] MSG_PORT,
    output logic [15:0] MSG_COUNT,
    output logic MSG_VALID,
    input wire logic MSG_READY,
    output logic VIRT_CHAR_EN,
    output logic REBOOT,
    output logic BUSY
);
    import srfl_pkg::*;

    typedef enum {
        ST_IDLE, ST_BOOTING, ST_ERASE, ST_RECV, ST_PROG, ST_REPORT, ST_DONE, ST_FAIL, ST_REBOOT
    } srfl_state_t;

    srfl_state_t state, next_state;
    srfl_msg_t msg, next_msg;
    logic msg_valid, next_msg_valid;
    logic [SRFL_CNT_W-1:0] rec_cnt, next_rec_cnt;
    logic [1:0] port, next_port;
    logic ack_mode, next_ack_mode, boot, next_boot, last, next_last;
    logic esc_seen, next_esc_seen, line_s, next_line_s, line_s8, next_line_s8;
    logic erase_req, next_erase_req, cfg_erase, next_cfg_erase, prog_req, next_prog_req;
    logic hs, next_hs, reboot, next_reboot;
    logic [31:0] wait_cnt, next_wait_cnt;
    logic [$clog2(SRFL_VIRT_CHAR_CYC)-1:0] pace, next_pace;
    logic esc_s1, esc_s2, erase_s1, erase_s2, prog_s1, prog_s2;
    logic f_valid, f_ready;
    srfl_char_t f_char;

    function automatic logic is_abort(input srfl_char_t c, input logic seen);
        return seen && (c.data == SRFL_CR);
    endfunction

    srfl_fifo #(.WIDTH($bits(srfl_char_t)), .DEPTH(SRFL_FIFO_D)) u_fifo (
        .clk(CORE_CLK),
        .rst(RST),
        .in_valid(RX_VALID),
        .in_ready(RX_READY),
        .in_data(RX_CHAR),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_char)
    );

    // characters drain only while receiving; stalls while flash is busy
    assign f_ready = (state == ST_RECV) && !msg_valid;

    // done strobes come from the flash macro clock domain
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            esc_s1 <= 1'b0;
            esc_s2 <= 1'b0;
            erase_s1 <= 1'b0;
            erase_s2 <= 1'b0;
            prog_s1 <= 1'b0;
            prog_s2 <= 1'b0;
        end
        else
        begin
            esc_s1 <= BOOT_ESC;
            esc_s2 <= esc_s1;
            erase_s1 <= ERASE_DONE;
            erase_s2 <= erase_s1;
            prog_s1 <= PROG_DONE;
            prog_s2 <= prog_s1;
        end
    end

    always_comb
    begin
        next_state = state;
        next_msg = msg;
        next_msg_valid = msg_valid && !MSG_READY;
        next_rec_cnt = rec_cnt;
        next_port = port;
        next_ack_mode = ack_mode;
        next_boot = boot;
        next_last = last;
        next_esc_seen = esc_seen;
        next_line_s = line_s;
        next_line_s8 = line_s8;
        next_erase_req = erase_req;
        next_cfg_erase = cfg_erase;
        next_prog_req = prog_req;
        next_hs = hs;
        next_reboot = 1'b0;
        next_wait_cnt = wait_cnt;
        next_pace = (pace == '0) ? ($bits(pace))'(SRFL_VIRT_CHAR_CYC - 1) : pace - 1'b1;
        case (state)
            ST_BOOTING:
            begin
                if (esc_s2)
                begin
                    next_boot = 1'b1;
                    next_port = SRFL_PORT_PRI;
                    next_msg = SRFL_MSG_BANNER;
                    next_msg_valid = 1'b1;
                    next_state = ST_IDLE;
                end
                else if (wait_cnt == '0)
                begin
                    next_state = ST_IDLE;
                    next_msg = SRFL_MSG_BANNER;
                    // banner goes to the primary port, never the virtual one
                    next_port = SRFL_PORT_PRI;
                    next_msg_valid = 1'b1;
                end
                else
                    next_wait_cnt = wait_cnt - 1;
            end
            ST_IDLE:
            begin
                if (RESET_CMD && !msg_valid)
                begin
                    next_state = ST_REBOOT;
                    next_reboot = 1'b1;
                end
                else if (CMD_VALID && CMD.start && !msg_valid
                         && (!boot || CMD.port == SRFL_PORT_PRI))
                begin
                    next_port = CMD.port;
                    next_ack_mode = CMD.ack_mode;
                    next_hs = boot ? 1'b1 : hs;
                    next_rec_cnt = '0;
                    next_erase_req = 1'b1;
                    next_cfg_erase = CFG_SIZE_DIFF && !boot;
                    next_msg = SRFL_MSG_ERASING;
                    next_msg_valid = 1'b1;
                    next_state = ST_ERASE;
                end
            end
            ST_ERASE:
            begin
                if (erase_s2 && !msg_valid)
                begin
                    next_erase_req = 1'b0;
                    next_cfg_erase = 1'b0;
                    next_msg = SRFL_MSG_READY;
                    next_msg_valid = 1'b1;
                    next_state = ST_RECV;
                    next_esc_seen = 1'b0;
                    next_line_s = 1'b0;
                    next_line_s8 = 1'b0;
                end
            end
            ST_RECV:
            begin
                if (REC_ERROR)
                begin
                    next_msg = SRFL_MSG_ERROR;
                    next_msg_valid = 1'b1;
                    next_state = ST_FAIL;
                end
                else if (f_valid && f_ready)
                begin
                    next_esc_seen = (f_char.data == SRFL_ESC);
                    if (is_abort(f_char, esc_seen))
                    begin
                        next_rec_cnt = '0;
                        next_state = ST_IDLE;
                    end
                    else if (f_char.data == SRFL_CR)
                    begin
                        if (line_s)
                        begin
                            next_last = line_s8;
                            next_prog_req = 1'b1;
                            next_state = ST_PROG;
                        end
                        next_line_s = 1'b0;
                    end
                    else if (f_char.data == SRFL_CH_S)
                        next_line_s = 1'b1;
                    else if (line_s && f_char.data == SRFL_CH_8)
                        next_line_s8 = 1'b1;
                end
            end
            ST_PROG:
            begin
                // no retransmission: a failed record ends the whole run
                if (REC_ERROR)
                begin
                    next_prog_req = 1'b0;
                    next_msg = SRFL_MSG_ERROR;
                    next_msg_valid = 1'b1;
                    next_state = ST_FAIL;
                end
                else if (prog_s2)
                begin
                    next_prog_req = 1'b0;
                    next_msg = ack_mode ? SRFL_MSG_ACK : SRFL_MSG_COUNT;
                    next_msg_valid = 1'b1;
                    next_state = ST_REPORT;
                end
            end
            ST_REPORT:
            begin
                if (!msg_valid)
                begin
                    next_rec_cnt = rec_cnt + 1'b1;
                    next_line_s8 = 1'b0;
                    if (last)
                    begin
                        next_msg = SRFL_MSG_DONE;
                        next_msg_valid = 1'b1;
                        next_state = ST_DONE;
                    end
                    else
                        next_state = ST_RECV;
                end
            end
            ST_DONE, ST_FAIL:
            begin
                if (!msg_valid)
                    next_state = ST_IDLE;
            end
            ST_REBOOT:
            begin
                next_boot = 1'b0;
                next_wait_cnt = 32'(BOOT_WAIT_CYC);
                next_state = ST_BOOTING;
            end
            default:
                next_state = ST_IDLE;
        endcase
        // count holds while the closing message drains
        if (state == ST_DONE || state == ST_FAIL)
            next_rec_cnt = rec_cnt;
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= ST_BOOTING;
            msg <= SRFL_MSG_NONE;
            msg_valid <= 1'b0;
            rec_cnt <= '0;
            port <= SRFL_PORT_PRI;
            ack_mode <= 1'b0;
            boot <= 1'b0;
            last <= 1'b0;
            esc_seen <= 1'b0;
            line_s <= 1'b0;
            line_s8 <= 1'b0;
            erase_req <= 1'b0;
            cfg_erase <= 1'b0;
            prog_req <= 1'b0;
            hs <= 1'b0;
            reboot <= 1'b0;
            wait_cnt <= 32'(BOOT_WAIT_CYC);
            pace <= '0;
        end
        else
        begin
            state <= next_state;
            msg <= next_msg;
            msg_valid <= next_msg_valid;
            rec_cnt <= next_rec_cnt;
            port <= next_port;
            ack_mode <= next_ack_mode;
            boot <= next_boot;
            last <= next_last;
            esc_seen <= next_esc_seen;
            line_s <= next_line_s;
            line_s8 <= next_line_s8;
            erase_req <= next_erase_req;
            cfg_erase <= next_cfg_erase;
            prog_req <= next_prog_req;
            hs <= next_hs;
            reboot <= next_reboot;
            wait_cnt <= next_wait_cnt;
            pace <= next_pace;
        end
    end

    assign BUSY = (state != ST_IDLE);
    // echo and prompt are off while a run is active on the chosen port
    assign ECHO_ENABLE = !(BUSY && state != ST_BOOTING);
    assign PROMPT_ENABLE = !(BUSY && state != ST_BOOTING);
    assign ACTIVE_PORT = port;
    assign MSG = msg;
    assign MSG_VALID = msg_valid;
    assign MSG_PORT = port;
    assign MSG_COUNT = rec_cnt;
    assign ERASE_REQ = erase_req;
    assign CFG_ERASE_REQ = cfg_erase;
    assign PROG_REQ = prog_req;
    assign HW_HANDSHAKE = hs;
    assign REBOOT = reboot;
    assign VIRT_CHAR_EN = (pace == '0);
endmodule
`default_nettype wire

// File: srfl_loader_monitor.sv
// concurrent checks on the flash loader ports
`timescale 1ns/1ps
`default_nettype none
module srfl_loader_monitor
    import srfl_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire srfl_pkg::srfl_cmd_t CMD,
    input wire logic CMD_VALID,
    input wire logic RESET_CMD,
    input wire logic ERASE_REQ,
    input wire logic ERASE_DONE,
    input wire logic PROG_REQ,
    input wire logic ECHO_ENABLE,
    input wire logic PROMPT_ENABLE,
    input wire srfl_pkg::srfl_msg_t MSG,
    input wire logic [1:0] MSG_PORT,
    input wire logic [15:0] MSG_COUNT,
    input wire logic MSG_VALID,
    input wire logic MSG_READY,
    input wire logic VIRT_CHAR_EN,
    input wire logic REBOOT,
    input wire logic BUSY
);
    import srfl_pkg::*;
    localparam int GAP = SRFL_VIRT_CHAR_CYC - 1;
    logic [15:0] gap;
    logic seen_v;
    logic [15:0] last_ack;
    logic seen_ack;
    // cycles since the last virtual port slot, and the count of the last taken acknowledgement
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            gap <= 16'h0;
            seen_v <= 1'b0;
            last_ack <= 16'h0;
            seen_ack <= 1'b0;
        end
        else
        begin
            gap <= VIRT_CHAR_EN ? 16'h0 : gap + 16'h1;
            if (VIRT_CHAR_EN)
                seen_v <= 1'b1;
            if (MSG_VALID && MSG_READY && MSG == SRFL_MSG_ERASING)
                seen_ack <= 1'b0;
            else if (MSG_VALID && MSG_READY && MSG == SRFL_MSG_ACK)
            begin
                seen_ack <= 1'b1;
                last_ack <= MSG_COUNT;
            end
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    erase_start_a: assert property (CMD_VALID && CMD.start && CMD.port == SRFL_PORT_PRI
        && !BUSY && !MSG_VALID |=> ERASE_REQ && MSG_VALID && MSG == SRFL_MSG_ERASING)
        else $error("erase not started by program command");
    ready_after_a: assert property (ERASE_REQ && $rose(ERASE_DONE)
        |-> ##[2:4] (MSG_VALID && MSG == SRFL_MSG_READY))
        else $error("ready message late after erase");
    msg_hold_a: assert property (MSG_VALID && !MSG_READY
        |=> MSG_VALID && $stable(MSG) && $stable(MSG_COUNT) && $stable(MSG_PORT))
        else $error("message changed before taken");
    ack_count_a: assert property (MSG_VALID && MSG == SRFL_MSG_ACK
        |-> MSG_COUNT == (seen_ack ? last_ack + 16'h1 : 16'h0))
        else $error("acknowledge count out of sequence");
    quiet_prog_a: assert property (ERASE_REQ || PROG_REQ |-> !ECHO_ENABLE && !PROMPT_ENABLE)
        else $error("echo or prompt on while programming");
    banner_port_a: assert property (MSG_VALID && MSG == SRFL_MSG_BANNER
        |-> MSG_PORT == SRFL_PORT_PRI)
        else $error("banner on wrong port");
    reboot_pulse_a: assert property (RESET_CMD && !BUSY |-> ##[0:4] REBOOT ##1 !REBOOT)
        else $error("reboot pulse missing");
    virt_pace_a: assert property (VIRT_CHAR_EN && seen_v |-> gap == GAP[15:0])
        else $error("virtual port slot spacing wrong");
    cover property (MSG_VALID && MSG == SRFL_MSG_ACK && MSG_COUNT == 16'h0002);
    cover property (MSG_VALID && MSG == SRFL_MSG_DONE);
    cover property (MSG_VALID && MSG == SRFL_MSG_ERROR);
endmodule
bind srfl_loader srfl_loader_monitor srfl_loader_monitor_i (.CORE_CLK(CORE_CLK), .RST(RST),
    .CMD(CMD), .CMD_VALID(CMD_VALID), .RESET_CMD(RESET_CMD), .ERASE_REQ(ERASE_REQ),
    .ERASE_DONE(ERASE_DONE), .PROG_REQ(PROG_REQ), .ECHO_ENABLE(ECHO_ENABLE),
    .PROMPT_ENABLE(PROMPT_ENABLE), .MSG(MSG), .MSG_PORT(MSG_PORT), .MSG_COUNT(MSG_COUNT),
    .MSG_VALID(MSG_VALID), .MSG_READY(MSG_READY), .VIRT_CHAR_EN(VIRT_CHAR_EN),
    .REBOOT(REBOOT), .BUSY(BUSY));
`default_nettype wire

// File: srfl_flash_model.sv
// flash array and message sink model facing the loader
`timescale 1ns/1ps
`default_nettype none
module srfl_flash_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic erase_req,
    input wire logic prog_req,
    output logic erase_done,
    output logic prog_done,
    output logic msg_ready
);
    logic [7:0] wait_cnt;
    logic [2:0] free_cnt;
    // done lines stay up until the request drops
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_cnt <= 8'h00;
            free_cnt <= 3'h0;
            erase_done <= 1'b0;
            prog_done <= 1'b0;
        end
        else
        begin
            free_cnt <= free_cnt + 3'h1;
            wait_cnt <= ((erase_req && !erase_done) || (prog_req && !prog_done)) ?
                wait_cnt + 8'h01 : 8'h00;
            erase_done <= erase_req && (erase_done || wait_cnt == (slow ? 8'h3c : 8'h05));
            prog_done <= prog_req && (prog_done || wait_cnt == (slow ? 8'h3c : 8'h05));
        end
    end
    // a slow sink takes messages only half the time
    assign msg_ready = !slow || free_cnt[2];
endmodule
`default_nettype wire

// File: tb.sv
// testbench of the flash loader
`timescale 1ns/1ps
`default_nettype none
module tb;
    import srfl_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    srfl_cmd_t cmd = '0;
    srfl_char_t rx_char = '0;
    logic cmd_valid = 1'b0, reset_cmd = 1'b0, boot_esc = 1'b0, rx_valid = 1'b0;
    logic rec_error = 1'b0, cfg_diff = 1'b0, slow = 1'b0;
    logic rx_ready, erase_req, cfg_erase_req, erase_done, prog_req, prog_done, hw_hs;
    logic echo_en, prompt_en, virt_en, reboot, busy, msg_valid, msg_ready;
    logic [1:0] active_port, msg_port;
    logic [15:0] msg_count;
    srfl_msg_t msg;
    logic [20:0] mq[$];
    logic [20:0] last_e;
    int error_cnt = 0;
    int checked = 0;
    always #5 core_clk = ~core_clk;
    srfl_loader #(.BOOT_WAIT_CYC(20)) srfl_loader_i (.CORE_CLK(core_clk), .RST(rst),
        .CMD(cmd), .CMD_VALID(cmd_valid), .RESET_CMD(reset_cmd), .BOOT_ESC(boot_esc),
        .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_CHAR(rx_char), .REC_ERROR(rec_error),
        .CFG_SIZE_DIFF(cfg_diff), .ERASE_REQ(erase_req), .CFG_ERASE_REQ(cfg_erase_req),
        .ERASE_DONE(erase_done), .PROG_REQ(prog_req), .PROG_DONE(prog_done),
        .HW_HANDSHAKE(hw_hs), .ECHO_ENABLE(echo_en), .PROMPT_ENABLE(prompt_en),
        .ACTIVE_PORT(active_port), .MSG(msg), .MSG_PORT(msg_port), .MSG_COUNT(msg_count),
        .MSG_VALID(msg_valid), .MSG_READY(msg_ready), .VIRT_CHAR_EN(virt_en),
        .REBOOT(reboot), .BUSY(busy));
    srfl_flash_model srfl_flash_model_i (.clk(core_clk), .rst(rst), .slow(slow),
        .erase_req(erase_req), .prog_req(prog_req), .erase_done(erase_done),
        .prog_done(prog_done), .msg_ready(msg_ready));
    // every message taken by the sink, in order
    always @(posedge core_clk)
        if (!rst && msg_valid && msg_ready)
            mq.push_back({msg_port, msg, msg_count});
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %0h want %0h", $time, what, seen, exp);
        end
    endtask
    task close_out;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // takes up to tries messages looking for kind m
    task pop(input srfl_msg_t m, input logic [15:0] c, input bit use_c, input int tries);
        int n;
        bit hit;
        hit = 0;
        for (int k = 0; k < tries && !hit; k++)
        begin
            n = 0;
            while (mq.size() == 0 && n < 3000)
            begin
                @(posedge core_clk);
                n++;
            end
            if (mq.size() > 0)
            begin
                last_e = mq.pop_front();
                hit = (last_e[18:16] === m);
            end
        end
        chk(hit, 1, "message kind");
        if (use_c)
            chk(last_e[15:0], c, "message count");
    endtask
    task wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000)
        begin
            @(posedge core_clk);
            n++;
        end
        chk(busy, 0, "idle");
    endtask
    task send_ch(input logic [7:0] d, input logic [1:0] p);
        int n;
        n = 0;
        rx_char <= '{data: d, port: p};
        rx_valid <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (rx_ready !== 1'b1 && n < 3000);
    endtask
    task send_line(input logic [7:0] kind, input logic [1:0] p);
        send_ch(SRFL_CH_S, p);
        send_ch(kind, p);
        send_ch(8'h30, p);
        send_ch(8'h30, p);
        send_ch(SRFL_CR, p);
        rx_valid <= 1'b0;
    endtask
    task abort_seq(input logic [1:0] p);
        send_ch(SRFL_ESC, p);
        send_ch(SRFL_CR, p);
        rx_valid <= 1'b0;
    endtask
    task issue_cmd(input logic [1:0] p, input logic ack, input logic cfg);
        cmd <= '{start: 1'b1, ack_mode: ack, boot: 1'b0, port: p};
        cmd_valid <= 1'b1;
        cfg_diff <= cfg;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        @(posedge core_clk);
    endtask
    task start_prog(input logic [1:0] p, input logic ack, input logic cfg);
        wait_idle();
        issue_cmd(p, ack, cfg);
        chk(erase_req, 1, "erase request");
        chk({echo_en, prompt_en}, 0, "echo and prompt");
        chk(active_port, p, "active port");
        chk(cfg_erase_req, cfg, "config erase");
        pop(SRFL_MSG_ERASING, 0, 0, 1);
        pop(SRFL_MSG_READY, 0, 0, 1);
    endtask
    task t_ack(input logic [1:0] p, input int n, input logic cfg);
        start_prog(p, 1'b1, cfg);
        for (int i = 0; i < n; i++)
        begin
            send_line((i == n - 1) ? SRFL_CH_8 : 8'h31, p);
            pop(SRFL_MSG_ACK, i[15:0], 1, 1);
        end
        pop(SRFL_MSG_DONE, 0, 0, 1);
        wait_idle();
        chk({echo_en, prompt_en}, 2'h3, "echo restored");
    endtask
    task t_fill;
        int acc;
        acc = 0;
        wait_idle();
        for (int i = 0; i < 40; i++)
        begin
            rx_char <= '{data: (i == 30) ? SRFL_ESC : (i == 31) ? SRFL_CR : 8'h78,
                port: SRFL_PORT_PRI};
            rx_valid <= 1'b1;
            @(posedge core_clk);
            if (rx_ready !== 1'b1)
                break;
            acc++;
        end
        rx_valid <= 1'b0;
        chk(acc, SRFL_FIFO_D, "fifo depth");
        start_prog(SRFL_PORT_PRI, 1'b1, 1'b0);
        wait_idle();
        chk(mq.size(), 0, "no message after abort");
    endtask
    task t_misc;
        int n;
        start_prog(SRFL_PORT_VIRT, 1'b1, 1'b0);
        send_line(8'h31, SRFL_PORT_VIRT);
        pop(SRFL_MSG_ACK, 0, 1, 1);
        abort_seq(SRFL_PORT_VIRT);
        wait_idle();
        t_ack(SRFL_PORT_VIRT, 1, 1'b0);
        start_prog(SRFL_PORT_PRI, 1'b1, 1'b0);
        send_line(8'h31, SRFL_PORT_PRI);
        n = 0;
        while (prog_req !== 1'b1 && n < 3000)
        begin
            @(posedge core_clk);
            n++;
        end
        // error while the record is being programmed: no retry, run ends
        rec_error <= 1'b1;
        pop(SRFL_MSG_ERROR, 0, 0, 1);
        rec_error <= 1'b0;
        wait_idle();
        start_prog(SRFL_PORT_PRI, 1'b0, 1'b0);
        send_line(8'h31, SRFL_PORT_PRI);
        pop(SRFL_MSG_COUNT, 0, 0, 1);
        send_line(SRFL_CH_8, SRFL_PORT_PRI);
        pop(SRFL_MSG_DONE, 0, 0, 3);
        wait_idle();
        reset_cmd <= 1'b1;
        @(posedge core_clk);
        reset_cmd <= 1'b0;
        n = 0;
        while (reboot !== 1'b1 && n < 10)
        begin
            @(posedge core_clk);
            n++;
        end
        chk(reboot, 1, "reboot pulse");
    endtask
    task t_boot;
        rst <= 1'b1;
        boot_esc <= 1'b1;
        repeat (6) @(posedge core_clk);
        mq.delete();
        rst <= 1'b0;
        pop(SRFL_MSG_BANNER, 0, 0, 1);
        chk(last_e[20:19], SRFL_PORT_PRI, "boot banner port");
        boot_esc <= 1'b0;
        issue_cmd(SRFL_PORT_SEC, 1'b0, 1'b0);
        repeat (3) @(posedge core_clk);
        chk(erase_req, 0, "secondary refused");
        issue_cmd(SRFL_PORT_PRI, 1'b0, 1'b0);
        chk({hw_hs, erase_req}, 2'h3, "boot handshake and erase");
        pop(SRFL_MSG_READY, 0, 0, 2);
        send_line(SRFL_CH_8, SRFL_PORT_PRI);
        pop(SRFL_MSG_DONE, 0, 0, 3);
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        pop(SRFL_MSG_BANNER, 0, 0, 1);
        chk(last_e[20:19], SRFL_PORT_PRI, "banner port");
        t_fill();
        t_ack(SRFL_PORT_PRI, 3, 1'b1);
        t_ack(SRFL_PORT_SEC, 2, 1'b0);
        slow <= 1'b1;
        t_ack(SRFL_PORT_VIRT, 3, 1'b0);
        slow <= 1'b0;
        t_misc();
        repeat (70000) @(posedge core_clk);
        t_boot();
        close_out();
    end
    initial
    begin
        #900_000;
        error_cnt++;
        close_out();
    end
endmodule
`default_nettype wire
